/* hdl/kbe_echo_term.sv */
`timescale 1ns/10ps
module kbe_echo_term
	import kbe_pkg::*;
#(
	parameter int P_START_CYCLES = START_CYCLES,
	parameter int P_LOCKOUT_CYCLES = LOCKOUT_CYCLES
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Host word channel
	input wire logic [FW_W-1:0] i_func_word,
	input wire logic i_func_word_ack,
	input wire logic i_word_in_ack_alt,
	output logic o_func_word_request,
	output logic o_input_request,
	output logic o_interrupt_request,
	output logic [IN_REG_W-1:0] o_in_reg,
	// Keyboard and printer loop
	input wire logic i_key_line,
	input wire logic i_key_char_valid,
	input wire logic [IN_REG_W-1:0] i_key_char,
	output logic o_print_line_drive,
	output logic o_printer_motor_on,
	// Panel
	input wire logic i_kbd_clear_btn,
	input wire logic i_master_clear_btn,
	input wire logic i_interrupt_sel_btn,
	output logic o_key_entry_mode,
	output logic o_read_interlock,
	// Other console logic
	input wire logic i_reader_active,
	input wire logic i_serializer_start,
	input wire logic i_serializer_done,
	output logic o_serializer_init,
	output logic o_shifter_idle,
	output logic o_in_reg_reset,
	output logic o_key_to_in_reg_load
);

	typedef struct packed {
		logic kl_s1;
		logic kl_s2;
		logic kc_s1;
		logic kc_s2;
		logic mc_s1;
		logic mc_s2;
		logic mc_d;
		logic im_s1;
		logic im_s2;
		logic im_d;
		logic fw_ack_d;
		logic in_ack_d;
		logic key_entry_mode;
		logic line_ff;
		logic char_active;
		logic ready;
		logic req_en;
		logic req_en_d;
		logic dly_done;
		logic intr;
		logic shifter_idle;
		logic motor;
		logic [IN_REG_W-1:0] in_reg;
		logic in_reg_reset;
		logic load;
		logic print_drive;
		logic fw_req;
		logic in_req;
		logic int_req;
		logic ser_init;
	} kbe_state_t;

	kbe_state_t s;
	kbe_state_t next_s;

	kbe_timer_if t_fwp ();
	kbe_timer_if t_lock ();
	kbe_timer_if t_start ();
	kbe_timer_if t_ack ();
	kbe_timer_if t_dly ();

	logic fw_ack_edge;
	logic mc_press;
	logic term;
	logic enter;
	logic start_fire;

	// ************************************************************
	// Interval timers
	// ************************************************************
	kbe_timer #(.COUNT(ACK_PULSE_CYCLES)) u_fw_pulse (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.tif(t_fwp)
	);
	kbe_timer #(.COUNT(P_LOCKOUT_CYCLES)) u_lockout (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.tif(t_lock)
	);
	kbe_timer #(.COUNT(P_START_CYCLES)) u_start_gate (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.tif(t_start)
	);
	kbe_timer #(.COUNT(ACK_PULSE_CYCLES)) u_ack_pulse (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.tif(t_ack)
	);
	kbe_timer #(.COUNT(REQ_DELAY_CYCLES)) u_req_delay (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.tif(t_dly)
	);

	// ************************************************************
	// Events
	// ************************************************************
	assign fw_ack_edge = i_func_word_ack & ~s.fw_ack_d;
	assign mc_press = s.mc_s2 & ~s.mc_d;
	// Terminate command is honoured only while the acknowledge pulse
	// stands, so a word left on the lines later has no effect.
	assign term = (t_fwp.busy & i_func_word[FW_INPUT_SEL_BIT]
		& ~i_func_word[FW_KEY_ENABLE_BIT])
		| s.kc_s2
		| s.mc_s2;
	assign enter = t_fwp.busy & i_func_word[FW_INPUT_SEL_BIT]
		& i_func_word[FW_KEY_ENABLE_BIT];
	// A start gate begins on the first space after an idle mark.
	assign start_fire = s.key_entry_mode & ~s.char_active
		& s.line_ff & ~s.kl_s2;

	assign t_fwp.fire = fw_ack_edge;
	assign t_lock.fire = fw_ack_edge | mc_press;
	assign t_start.fire = start_fire;
	assign t_ack.fire = i_word_in_ack_alt & ~s.in_ack_d;
	assign t_dly.fire = s.req_en & ~s.req_en_d;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_s = s;
		// Two-stage synchronisers for buttons and the key line.
		next_s.kl_s1 = i_key_line;
		next_s.kl_s2 = s.kl_s1;
		next_s.kc_s1 = i_kbd_clear_btn;
		next_s.kc_s2 = s.kc_s1;
		next_s.mc_s1 = i_master_clear_btn;
		next_s.mc_s2 = s.mc_s1;
		next_s.mc_d = s.mc_s2;
		next_s.im_s1 = i_interrupt_sel_btn;
		next_s.im_s2 = s.im_s1;
		next_s.im_d = s.im_s2;
		next_s.fw_ack_d = i_func_word_ack;
		next_s.in_ack_d = i_word_in_ack_alt;

		// Mode, indicator, read interlock and printer motor.
		if (term) begin
			next_s.key_entry_mode = 1'b0;
		end else if (enter) begin
			next_s.key_entry_mode = 1'b1;
		end
		next_s.motor = next_s.key_entry_mode;

		// Keyboard line flop; once out of the mode it only sets.
		if (s.kl_s2) begin
			next_s.line_ff = 1'b1;
		end else if (s.key_entry_mode) begin
			next_s.line_ff = 1'b0;
		end

		if (start_fire) begin
			next_s.char_active = 1'b1;
		end else if (i_key_char_valid || !s.key_entry_mode) begin
			next_s.char_active = 1'b0;
		end

		// Character arrival, acknowledge and termination.
		next_s.load = i_key_char_valid & s.key_entry_mode
			& ~term;
		if (t_ack.busy) begin
			next_s.ready = 1'b0;
		end
		if (next_s.load) begin
			next_s.ready = 1'b1;
		end
		if (term) begin
			next_s.ready = 1'b0;
		end
		next_s.req_en = s.ready & ~t_ack.busy & ~term;
		next_s.req_en_d = s.req_en;
		next_s.dly_done = s.req_en
			& (s.dly_done | (s.req_en_d & ~t_dly.busy));
		if (t_ack.busy) begin
			next_s.intr = 1'b0;
		end
		if (s.im_s2 && !s.im_d) begin
			next_s.intr = 1'b1;
		end
		if (term) begin
			next_s.intr = 1'b0;
		end

		// Input register.
		next_s.in_reg_reset = ~i_reader_active & ~t_ack.busy
			& ~s.ready;
		if (s.load) begin
			next_s.in_reg = i_key_char;
		end else if (s.in_reg_reset) begin
			next_s.in_reg = IN_REG_RESET;
		end

		// Requests to the host.
		next_s.in_req = s.req_en & s.dly_done & ~s.intr
			& ~i_reader_active;
		next_s.int_req = s.req_en & s.dly_done & s.intr
			& ~i_reader_active;
		next_s.fw_req = s.shifter_idle & ~t_lock.busy;

		// Serializer start is held off during key entry.
		next_s.ser_init = i_serializer_start & s.shifter_idle
			& ~s.key_entry_mode;
		if (mc_press) begin
			next_s.shifter_idle = 1'b1;
		end else if (s.ser_init) begin
			next_s.shifter_idle = 1'b0;
		end else if (i_serializer_done) begin
			next_s.shifter_idle = 1'b1;
		end

		// Printer drive: high is space, low is mark.
		next_s.print_drive = t_start.busy | ~s.line_ff;
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			s <= '0;
			s.line_ff <= 1'b1;
			s.kl_s1 <= 1'b1;
			s.kl_s2 <= 1'b1;
			s.shifter_idle <= 1'b1;
			s.fw_ack_d <= 1'b1;
			s.in_ack_d <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign o_func_word_request = s.fw_req;
	assign o_input_request = s.in_req;
	assign o_interrupt_request = s.int_req;
	assign o_in_reg = s.in_reg;
	assign o_print_line_drive = s.print_drive;
	assign o_printer_motor_on = s.motor;
	assign o_key_entry_mode = s.key_entry_mode;
	assign o_read_interlock = s.key_entry_mode;
	assign o_serializer_init = s.ser_init;
	assign o_shifter_idle = s.shifter_idle;
	assign o_in_reg_reset = s.in_reg_reset;
	assign o_key_to_in_reg_load = s.load;

endmodule

/* hdl/kbe_pkg.sv */
package kbe_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int TIMER_W = 24;

	// Start-pulse gate of every keyboard character.
	localparam int START_PULSE_NS = 9_090_000;
	localparam int START_CYCLES =
		(START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Lockout of function-word requests.
	localparam int LOCKOUT_NS = 70_000_000;
	localparam int LOCKOUT_CYCLES =
		(LOCKOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Internal pulse made from each acknowledge.
	localparam int ACK_PULSE_NS = 2_000;
	localparam int ACK_PULSE_CYCLES =
		(ACK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Delay from request enable to the request itself.
	localparam int REQ_DELAY_NS = 4_400;
	localparam int REQ_DELAY_CYCLES =
		(REQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ************************************************************
	// Function word fields
	// ************************************************************
	localparam int FW_W = 8;
	localparam int FW_INPUT_SEL_BIT = 3;
	localparam int FW_KEY_ENABLE_BIT = 4;

	// ************************************************************
	// Input register
	// ************************************************************
	localparam int IN_REG_W = 8;
	localparam logic [7:0] IN_REG_RESET = 8'h00;

endpackage

/* hdl/kbe_timer_if.sv */
`timescale 1ns/10ps
interface kbe_timer_if;
	logic fire;
	logic busy;
	modport owner (output fire, input busy);
	modport timer (input fire, output busy);
endinterface

/* hdl/kbe_timer.sv */
`timescale 1ns/10ps
module kbe_timer
	import kbe_pkg::*;
#(
	parameter int COUNT = 1
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Trigger and gate
	kbe_timer_if.timer tif
);

	typedef struct packed {
		logic [TIMER_W-1:0] cnt;
		logic busy;
	} kbe_tmr_t;

	kbe_tmr_t s;
	kbe_tmr_t next_s;

	// ************************************************************
	// Gate of COUNT cycles, restarted by every fire.
	// ************************************************************
	always_comb begin
		next_s = s;
		if (tif.fire) begin
			next_s.cnt = TIMER_W'(COUNT - 1);
			next_s.busy = 1'b1;
		end else if (s.busy) begin
			if (s.cnt == '0) begin
				next_s.busy = 1'b0;
			end else begin
				next_s.cnt = s.cnt - TIMER_W'(1);
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tif.busy = s.busy;

endmodule

/* test/kbe_echo_term_chk.sv */
`timescale 1ns/10ps
// ****
// Echo and termination checks
// ****
module kbe_echo_term_chk
	import kbe_pkg::*;
#(
	parameter int P_START_CYCLES = 40
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Inputs
	input wire logic i_func_word_ack,
	input wire logic i_word_in_ack_alt,
	input wire logic i_key_line,
	input wire logic i_key_char_valid,
	input wire logic [IN_REG_W-1:0] i_key_char,
	// Outputs
	input wire logic o_func_word_request,
	input wire logic o_input_request,
	input wire logic o_interrupt_request,
	input wire logic [IN_REG_W-1:0] o_in_reg,
	input wire logic o_print_line_drive,
	input wire logic o_printer_motor_on,
	input wire logic o_key_entry_mode,
	input wire logic o_read_interlock,
	input wire logic o_serializer_init,
	input wire logic o_in_reg_reset,
	input wire logic o_key_to_in_reg_load
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	logic [15:0] idle_n;
	// Counts only at mark, as a flop cleared mid-frame shows space.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n || o_key_entry_mode || !i_key_line)
			idle_n <= 16'h0000;
		else if (idle_n != 16'hFFFF)
			idle_n <= idle_n + 16'h0001;
	end
	sequence s_fw_ack;
		$rose(i_func_word_ack);
	endsequence
	sequence s_load;
		##1 o_key_to_in_reg_load ##1 (o_in_reg == $past(i_key_char, 2));
	endsequence
	a_no_init_mode:
		assert property (o_key_entry_mode |-> !o_serializer_init)
			else $error("serializer started in key mode");
	a_mode_outputs:
		assert property (o_printer_motor_on == o_key_entry_mode &&
			o_read_interlock == o_key_entry_mode) else $error("motor");
	a_fw_lockout:
		assert property (s_fw_ack |-> ##2 (!o_func_word_request) [*8])
			else $error("lockout");
	a_in_ack_drop:
		assert property ($rose(i_word_in_ack_alt) |->
			##3 !(o_input_request || o_interrupt_request)) else $error("ack");
	a_reg_cleared:
		assert property (o_in_reg_reset [*2] |-> o_in_reg == IN_REG_RESET)
			else $error("in reg");
	a_no_req_idle:
		assert property (o_in_reg_reset [*3] |->
			!o_input_request && !o_interrupt_request) else $error("req");
	a_char_loaded:
		assert property (o_key_entry_mode && i_key_char_valid &&
			o_in_reg_reset |-> s_load) else $error("load");
	// The line passes two synchroniser stages and the line flop first.
	a_echo_space:
		assert property ((o_key_entry_mode && !i_key_line) [*4] |=>
			o_print_line_drive) else $error("echo");
	a_mark_held:
		assert property (idle_n > P_START_CYCLES + 4 |-> !o_print_line_drive)
			else $error("mark");
endmodule
bind kbe_echo_term kbe_echo_term_chk #(.P_START_CYCLES(P_START_CYCLES))
	i_kbe_echo_term_chk (.i_clock, .i_rst_n, .i_func_word_ack,
	.i_word_in_ack_alt, .i_key_line, .i_key_char_valid, .i_key_char,
	.o_func_word_request, .o_input_request, .o_interrupt_request,
	.o_in_reg, .o_print_line_drive, .o_printer_motor_on,
	.o_key_entry_mode, .o_read_interlock, .o_serializer_init,
	.o_in_reg_reset, .o_key_to_in_reg_load);

/* test/kbe_host_model.sv */
`timescale 1ns/10ps
// ****
// Host acknowledge model
// ****
module kbe_host_model (
	// Clock
	input wire logic i_clock,
	// Request and pacing
	input wire logic i_req,
	input wire logic [7:0] i_delay,
	// Acknowledge
	output logic o_ack
);
	logic [7:0] wait_n = 8'h00;
	initial o_ack = 1'b0;
	// A long delay shows that the request is held until acknowledged.
	always @(posedge i_clock) begin
		#1;
		if (!i_req) begin
			wait_n = 8'h00;
			o_ack = 1'b0;
		end else if (wait_n == i_delay)
			o_ack = 1'b1;
		else
			wait_n = wait_n + 8'h01;
	end
endmodule

/* test/tb_kbe_echo_term.sv */
`timescale 1ns/10ps
// ****
// Bench
// ****
module tb_kbe_echo_term;
	logic i_clock = 0, i_rst_n = 0, i_func_word_ack = 0, i_word_in_ack_alt;
	logic i_key_line = 1, i_key_char_valid = 0, i_kbd_clear_btn = 0;
	logic i_master_clear_btn = 0, i_interrupt_sel_btn = 0;
	logic i_serializer_done = 0, i_reader_active = 0;
	logic i_serializer_start = 0, o_func_word_request, o_input_request;
	logic o_interrupt_request, o_print_line_drive, o_printer_motor_on;
	logic o_key_entry_mode, o_read_interlock, o_serializer_init;
	logic o_shifter_idle, o_in_reg_reset, o_key_to_in_reg_load;
	logic [7:0] i_func_word = 8'h00, i_key_char = 8'h00, dly = 8'h03;
	logic [7:0] o_in_reg;
	int n_mismatch = 0, total_checks = 0, cyc = 0, n;
	kbe_echo_term #(.P_START_CYCLES(40), .P_LOCKOUT_CYCLES(50))
		i_kbe_echo_term (.i_clock, .i_rst_n, .i_func_word,
		.i_func_word_ack, .i_word_in_ack_alt, .o_func_word_request,
		.o_input_request, .o_interrupt_request, .o_in_reg, .i_key_line,
		.i_key_char_valid, .i_key_char, .o_print_line_drive,
		.o_printer_motor_on, .i_kbd_clear_btn, .i_master_clear_btn,
		.i_interrupt_sel_btn, .o_key_entry_mode, .o_read_interlock,
		.i_reader_active, .i_serializer_start,
		.i_serializer_done, .o_serializer_init, .o_shifter_idle,
		.o_in_reg_reset, .o_key_to_in_reg_load);
	kbe_host_model i_kbe_host_model (.i_clock, .i_delay(dly),
		.i_req(o_input_request | o_interrupt_request),
		.o_ack(i_word_in_ack_alt));
	initial forever #4 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			results();
		end
	end
	task results();
		if (n_mismatch == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task tk(input int k);
		repeat (k) @(posedge i_clock);
		#1;
	endtask
	task fw(input logic [7:0] w, input logic m);
		i_func_word = w;
		i_func_word_ack = 1;
		tk(3);
		chk("mode", o_key_entry_mode, m);
		chk("motor", o_printer_motor_on, m);
		tk(30);
		chk("lock", o_func_word_request, 0);
		tk(230);
		chk("fwreq", o_func_word_request, 1);
		i_func_word_ack = 0;
		tk(1);
	endtask
	task t_ser(input logic done);
		i_serializer_start = 1;
		tk(1);
		i_serializer_start = 0;
		chk("init", o_serializer_init, 1);
		tk(2);
		chk("idle", o_shifter_idle, 0);
		chk("fwreq", o_func_word_request, 0);
		i_serializer_done = done;
		tk(1);
		i_serializer_done = 0;
		tk(2);
		chk("idle", o_shifter_idle, done);
	endtask
	task t_rdr();
		i_reader_active = 1;
		tk(3);
		chk("clr", o_in_reg_reset, 0);
		i_reader_active = 0;
		tk(3);
		chk("clr", o_in_reg_reset, 1);
	endtask
	task t_rst();
		i_rst_n = 0;
		tk(3);
		chk("mode", o_key_entry_mode, 0);
		chk("mark", o_print_line_drive, 0);
		chk("idle", o_shifter_idle, 1);
		i_rst_n = 1;
		tk(2);
		chk("fwreq", o_func_word_request, 1);
		chk("clr", o_in_reg_reset, 1);
	endtask
	task t_echo();
		i_serializer_start = 1;
		tk(1);
		i_serializer_start = 0;
		chk("init", o_serializer_init, 0);
		i_key_line = 0;
		tk(4);
		chk("echo", o_print_line_drive, 1);
		i_key_line = 1;
		tk(4);
		chk("gate", o_print_line_drive, 1);
		tk(45);
		chk("echo", o_print_line_drive, 0);
		i_key_line = 0;
		tk(4);
		chk("echo", o_print_line_drive, 1);
		i_key_line = 1;
		tk(4);
		chk("echo", o_print_line_drive, 0);
	endtask
	task t_char(input logic [7:0] c, input logic it);
		i_interrupt_sel_btn = it;
		tk(4);
		i_interrupt_sel_btn = 0;
		i_key_char = c;
		i_key_char_valid = 1;
		tk(1);
		i_key_char_valid = 0;
		tk(2);
		chk("inreg", o_in_reg, c);
		n = 0;
		while (!(o_input_request | o_interrupt_request) && n < 900) begin
			tk(1);
			n++;
		end
		chk("delay", n > 530 && n < 570, 1);
		chk("intr", o_interrupt_request, it);
		chk("dreq", o_input_request, !it);
		n = 0;
		while ((o_input_request | o_interrupt_request) && n < 300) begin
			tk(1);
			n++;
		end
		chk("held", n > dly && n < 300, 1);
		tk(260);
		chk("clr", o_in_reg, 8'h00);
		chk("clr", o_in_reg_reset, 1);
	endtask
	task t_clr(input logic m);
		i_kbd_clear_btn = !m;
		i_master_clear_btn = m;
		tk(5);
		chk("mode", o_key_entry_mode, 0);
		chk("intlk", o_read_interlock, 0);
		chk("fwreq", o_func_word_request, !m);
		i_kbd_clear_btn = 0;
		i_master_clear_btn = 0;
		tk(60);
		chk("fwreq", o_func_word_request, 1);
		chk("idle", o_shifter_idle, 1);
	endtask
	initial begin
		tk(16);
		i_rst_n = 1;
		chk("idle", o_shifter_idle, 1);
		chk("mark", o_print_line_drive, 0);
		tk(2);
		chk("fwreq", o_func_word_request, 1);
		t_ser(1);
		t_rdr();
		fw(8'h18, 1);
		t_echo();
		t_char(8'hC1, 0);
		dly = 8'h28;
		t_char(8'h5A, 1);
		fw(8'h40, 1);
		fw(8'h10, 1);
		i_key_char = 8'h3C;
		i_key_char_valid = 1;
		tk(1);
		i_key_char_valid = 0;
		tk(3);
		fw(8'h08, 0);
		i_key_char_valid = 1;
		tk(1);
		i_key_char_valid = 0;
		tk(600);
		chk("dreq", o_input_request, 0);
		chk("clr", o_in_reg, 8'h00);
		chk("mark", o_print_line_drive, 0);
		fw(8'h18, 1);
		t_rst();
		fw(8'h18, 1);
		t_clr(0);
		fw(8'h18, 1);
		t_clr(1);
		// Left busy on purpose: of the two clears, only the global clear can free it.
		t_ser(0);
		t_clr(1);
		results();
	end
endmodule
